// File: hw/rstmr_timer.sv
// rstmr_timer: second general 16-bit down-counting timer with apb registers and interrupt.
// assumes: apb master on sys_clk; txEnd, rxFirstBits and the underflow inputs are
// one-cycle pulses from logic on sys_clk; rfClkPin and lfoPin are asynchronous pins.
//
// Behaviour
// - stop-on-receive halts timer after four bits
// - stop-on-receive ignored in trimming modes
// - mode 00 no auto start, 01 on tx end
// - modes 10/11 trimming, start/stop on posedge
// - auto restart reloads and continues at zero, except in mode 10
// - without restart, stop and hold zero
// - underflow sets the interrupt flag except in mode 10
// - clock select: rf, 212k, timer underflows
// - each start loads the reload value
// - reload writes wait for next start or restart
// - live count readable as two bytes
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module rstmr_timer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // apb slave
    input wire rstmr_pkg::rstmr_apb_req_t apbReq,
    output rstmr_pkg::rstmr_apb_rsp_t apbRsp,
    // pins
    input wire logic rfClkPin,
    input wire logic lfoPin,
    // frontend events
    input wire logic txEnd,
    input wire logic rxFirstBits,
    input wire logic timerZeroUnderflow,
    input wire logic timerOneUnderflow,
    // results
    output logic irq,
    output logic underflowPulse
);
    import rstmr_pkg::*;

    typedef struct packed {
        rstmr_ctrl_t ctrl;
        logic [BYTE_W-1:0] reloadHigh;
        logic [BYTE_W-1:0] reloadLow;
        logic [2*BYTE_W-1:0] count;
        rstmr_run_t run;
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] irqEnable;
        logic irq;
        logic underflowPulse;
        rstmr_apb_rsp_t rsp;
    } rstmr_st_t;

    rstmr_st_t st;
    rstmr_st_t next_st;

    logic rfRise;
    logic lfoRise;
    logic tick;

    // bus decode, timer events and helpers
    logic setupPhase;
    logic accessPhase;
    logic writeOk;
    logic [IDX_W-1:0] index;
    logic aligned;
    logic [IRQ_W-1:0] clearMask;
    logic [IRQ_W-1:0] setMask;
    logic swStart;
    logic swStop;
    logic trimming;
    logic startEvent;
    logic stopEvent;
    logic rxHalt;
    logic cmdWrite;
    logic txStart;
    logic lfoStart;
    logic lfoStop;
    logic atBottom;
    logic silentEnd;
    logic [2*BYTE_W-1:0] reloadValue;
    logic [DATA_W-1:0] readData;
    logic readErr;

    // rf carrier pin: its rising edges drive the rf and 212 kHz count clock sources
    // only edges matter, so the level outputs stay open
    rstmr_sync u_rf_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pinIn(rfClkPin),
        .level(),
        .rise(rfRise)
    );

    // oscillator-trimming reference pin
    // rising edges start and stop the trimming count
    rstmr_sync u_lfo_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pinIn(lfoPin),
        .level(),
        .rise(lfoRise)
    );

    // count clock selection and 212 kHz divider
    // a tick lags its source by one cycle, the count by two
    rstmr_tick u_tick (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .rfRise(rfRise),
        .timerZeroUnderflow(timerZeroUnderflow),
        .timerOneUnderflow(timerOneUnderflow),
        .countClockSelect(st.ctrl.countClockSelect),
        .tick(tick)
    );

    // apb phase decode; pready is held high so every access ends in its first cycle
    // no wait states once running: pready is low only until the first edge after reset
    always_comb
    begin
        setupPhase = apbReq.psel && !apbReq.penable;
        accessPhase = apbReq.psel && apbReq.penable && st.rsp.pready;
        writeOk = accessPhase && apbReq.pwrite && !st.rsp.pslverr;
        index = apbReq.paddr[ADDR_W-1:IDX_LSB];
        aligned = (apbReq.paddr[IDX_LSB-1:0] == ALIGN_OK);
    end

    // register read mux; a refused access reads zero so no byte leaks out
    always_comb
    begin
        readData = '0;
        readErr = !aligned;
        if (aligned)
        begin
            case (index)
                IDX_CONTROL: readData[BYTE_W-1:0] = st.ctrl;
                IDX_RELOAD_HIGH: readData[BYTE_W-1:0] = st.reloadHigh;
                IDX_RELOAD_LOW: readData[BYTE_W-1:0] = st.reloadLow;
                // live bytes, not latched: high then low can tear while counting
                IDX_COUNT_HIGH: readData[BYTE_W-1:0] = st.count[2*BYTE_W-1:BYTE_W];
                IDX_COUNT_LOW: readData[BYTE_W-1:0] = st.count[BYTE_W-1:0];
                IDX_IRQ_STATUS: readData[IRQ_W-1:0] = st.status;
                IDX_IRQ_ENABLE: readData[IRQ_W-1:0] = st.irqEnable;
                // clear and command are write-only and read as zero
                IDX_IRQ_CLEAR: readData = '0;
                IDX_COMMAND: readData = '0;
                default: readErr = 1'b1;
            endcase
        end
    end

    // timer event decode from the current control byte
    always_comb
    begin
        trimming = st.ctrl.startMode[1];
        cmdWrite = writeOk && (index == IDX_COMMAND);
        swStart = cmdWrite && apbReq.pwdata[CMD_START_BIT];
        swStop = cmdWrite && apbReq.pwdata[CMD_STOP_BIT];
        // trimming modes mask the receive stop
        // a halt keeps the count and records the cause in status
        rxHalt = !trimming && st.ctrl.stopOnReceive && rxFirstBits && (st.run == TMR_RUN);
        // the reference edge toggles the run state in both trimming modes
        lfoStart = trimming && lfoRise && (st.run == TMR_IDLE);
        lfoStop = trimming && lfoRise && (st.run == TMR_RUN);
        // mode 00 starts only by command, 01 on end of transmission
        txStart = (st.ctrl.startMode == START_TX_END) && txEnd;
        startEvent = swStart || txStart || lfoStart;
        stopEvent = swStop || rxHalt || lfoStop;
        // value a start or restart loads; a mid-count reload write waits here
        reloadValue = {st.reloadHigh, st.reloadLow};
        // last tick of a count; a reload of zero ends on its first tick
        atBottom = (st.count <= COUNT_ONE);
        silentEnd = (st.ctrl.startMode == START_TRIM_NO_UF);
    end

    // next state: bus, then timer, then interrupt
    always_comb
    begin
        next_st = st;
        // pulses drop by default; pready rises after reset and stays
        next_st.underflowPulse = 1'b0;
        next_st.rsp.pready = 1'b1;
        clearMask = '0;
        setMask = '0;

        // read data and error are registered in the setup cycle
        if (setupPhase)
        begin
            // so they stand through the whole access cycle
            next_st.rsp.prdata = readData;
            next_st.rsp.pslverr = readErr;
        end

        // writes take effect in the access cycle only
        if (writeOk)
        begin
            case (index)
                // reserved bits are forced to zero on every write
                IDX_CONTROL:
                begin
                    next_st.ctrl = apbReq.pwdata[BYTE_W-1:0];
                    next_st.ctrl.reserved6 = 1'b0;
                    next_st.ctrl.reserved2 = 1'b0;
                end
                // only the stored bytes change; the count is untouched until a start or restart
                IDX_RELOAD_HIGH: next_st.reloadHigh = apbReq.pwdata[BYTE_W-1:0];
                IDX_RELOAD_LOW: next_st.reloadLow = apbReq.pwdata[BYTE_W-1:0];
                IDX_IRQ_CLEAR: clearMask = apbReq.pwdata[IRQ_W-1:0];
                IDX_IRQ_ENABLE: next_st.irqEnable = apbReq.pwdata[IRQ_W-1:0];
                // count, status and command: nothing stored here
                default: next_st.irqEnable = next_st.irqEnable;
            endcase
        end

        // start wins over stop; a stop holds the count where it is
        if (startEvent)
        begin
            next_st.count = reloadValue;
            next_st.run = TMR_RUN;
        end
        else if (stopEvent)
        begin
            // a stop keeps the count where it halted
            next_st.run = TMR_IDLE;
            if (rxHalt)
                setMask[IRQ_RX_STOP_BIT] = 1'b1;
        end
        else
        begin
            case (st.run)
                TMR_RUN:
                begin
                    if (tick)
                    begin
                        // a reload of zero also ends on the first tick, with an underflow outside mode 10
                        if (atBottom)
                        begin
                            if (silentEnd)
                            begin
                                // trimming without underflow just ends at zero
                                next_st.count = COUNT_RESET;
                                next_st.run = TMR_IDLE;
                            end
                            else
                            begin
                                setMask[IRQ_UNDERFLOW_BIT] = 1'b1;
                                next_st.underflowPulse = 1'b1;
                                // restart reloads and runs on
                                if (st.ctrl.autoReloadRestart)
                                    next_st.count = reloadValue;
                                else
                                begin
                                    // one-shot holds zero until the next start
                                    next_st.count = COUNT_RESET;
                                    next_st.run = TMR_IDLE;
                                end
                            end
                        end
                        // ordinary tick: one step down
                        else
                            next_st.count = st.count - COUNT_ONE;
                    end
                end
                // ticks are ignored while idle
                TMR_IDLE: next_st.run = TMR_IDLE;
                default: next_st.run = TMR_IDLE;
            endcase
        end

        // sticky flags: a set in the same cycle as its clear survives
        next_st.status = (st.status & ~clearMask) | setMask;
        // irq follows the new status, so it rises with the flag
        next_st.irq = |(next_st.status & next_st.irqEnable);
    end

    // state register
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            // pready stays low until the first edge after release
            st.ctrl <= CTRL_RESET;
            st.reloadHigh <= RELOAD_RESET;
            st.reloadLow <= RELOAD_RESET;
            st.count <= COUNT_RESET;
            st.run <= TMR_IDLE;
            st.status <= IRQ_RESET;
            st.irqEnable <= IRQ_RESET;
            st.irq <= 1'b0;
            st.underflowPulse <= 1'b0;
            st.rsp <= '0;
        end
        else
            st <= next_st;
    end

    // outputs straight from the state register
    assign apbRsp = st.rsp;
    assign irq = st.irq;
    assign underflowPulse = st.underflowPulse;
endmodule : rstmr_timer

// File: hw/rstmr_pkg.sv
// rstmr_pkg: constants, register layout and carrier types of the reader frontend second timer.
// assumes: one 200 MHz system clock, APB register access with 32-bit data.
package rstmr_pkg;

    // apb widths; byte address = register index times four
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IDX_W = 8;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned BYTE_W = 8;
    localparam logic [IDX_LSB-1:0] ALIGN_OK = 2'h0;

    // register indices
    localparam logic [IDX_W-1:0] IDX_CONTROL = 8'h19;
    localparam logic [IDX_W-1:0] IDX_RELOAD_HIGH = 8'h1a;
    localparam logic [IDX_W-1:0] IDX_RELOAD_LOW = 8'h1b;
    localparam logic [IDX_W-1:0] IDX_COUNT_HIGH = 8'h1c;
    localparam logic [IDX_W-1:0] IDX_COUNT_LOW = 8'h1d;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'h30;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 8'h31;
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 8'h32;
    localparam logic [IDX_W-1:0] IDX_COMMAND = 8'h33;

    // interrupt and command bit positions
    localparam int unsigned IRQ_W = 2;
    localparam int unsigned IRQ_UNDERFLOW_BIT = 0;
    localparam int unsigned IRQ_RX_STOP_BIT = 1;
    localparam int unsigned CMD_START_BIT = 0;
    localparam int unsigned CMD_STOP_BIT = 1;

    // reset values
    localparam logic [BYTE_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [BYTE_W-1:0] RELOAD_RESET = 8'h00;
    localparam logic [2*BYTE_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [2*BYTE_W-1:0] COUNT_ONE = 16'h0001;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    // 13.56 MHz divided by 64 gives the 212 kHz count clock
    localparam int unsigned SUB_DIV = 64;
    localparam int unsigned DIV_W = 6;
    localparam logic [DIV_W-1:0] SUB_DIV_LAST = DIV_W'(SUB_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_RESET = 6'h00;
    localparam logic [DIV_W-1:0] DIV_STEP = 6'h01;

    // start-mode codes
    typedef enum logic [1:0] {
        START_NONE = 2'b00,
        START_TX_END = 2'b01,
        START_TRIM_NO_UF = 2'b10,
        START_TRIM_UF = 2'b11
    } rstmr_start_t;

    // count clock codes
    typedef enum logic [1:0] {
        CLK_RF = 2'b00,
        CLK_SUB = 2'b01,
        CLK_T0_UF = 2'b10,
        CLK_T1_UF = 2'b11
    } rstmr_clk_t;

    // run state, one-hot
    typedef enum logic [1:0] {
        TMR_IDLE = 2'b01,
        TMR_RUN = 2'b10
    } rstmr_run_t;

    // control byte layout, bit 7 down to bit 0
    typedef struct packed {
        logic stopOnReceive;
        logic reserved6;
        rstmr_start_t startMode;
        logic autoReloadRestart;
        logic reserved2;
        rstmr_clk_t countClockSelect;
    } rstmr_ctrl_t;

    // apb request and answer carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } rstmr_apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } rstmr_apb_rsp_t;

endpackage : rstmr_pkg

// File: hw/rstmr_sync.sv
// rstmr_sync: three-stage synchroniser for one pin level, with a rising-edge pulse.
// assumes: the pin is asynchronous to sys_clk and slower than half its rate.
`timescale 1ns/1ps
module rstmr_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // pin side
    input wire logic pinIn,
    // synchronous side
    output logic level,
    output logic rise
);
    import rstmr_pkg::*;

    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic level;
        logic rise;
    } rstmr_sync_st_t;

    rstmr_sync_st_t st;
    rstmr_sync_st_t next_st;

    // a change counts only once stages two and three agree; ff1 feeds ff2 alone
    always_comb
    begin
        next_st = st;
        next_st.ff1 = pinIn;
        next_st.ff2 = st.ff1;
        next_st.ff3 = st.ff2;
        next_st.rise = 1'b0;
        if (st.ff2 == st.ff3)
        begin
            next_st.level = st.ff3;
            next_st.rise = st.ff3 && !st.level;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            st <= '0;
        else
            st <= next_st;
    end

    assign level = st.level;
    assign rise = st.rise;
endmodule : rstmr_sync

// File: hw/rstmr_tick.sv
// rstmr_tick: picks the count clock and turns it into one-cycle ticks.
// assumes: rfRise marks each 13.56 MHz edge; underflow inputs are sys_clk pulses.
`timescale 1ns/1ps
module rstmr_tick (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // tick sources
    input wire logic rfRise,
    input wire logic timerZeroUnderflow,
    input wire logic timerOneUnderflow,
    input wire rstmr_pkg::rstmr_clk_t countClockSelect,
    // selected tick
    output logic tick
);
    import rstmr_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic tick;
    } rstmr_tick_st_t;

    rstmr_tick_st_t st;
    rstmr_tick_st_t next_st;
    logic subTick;

    // divider runs always so the 212 kHz phase does not depend on the select
    always_comb
    begin
        next_st = st;
        subTick = 1'b0;
        if (rfRise)
        begin
            if (st.div == SUB_DIV_LAST)
            begin
                next_st.div = DIV_RESET;
                subTick = 1'b1;
            end
            else
                next_st.div = st.div + DIV_STEP;
        end
        case (countClockSelect)
            CLK_RF: next_st.tick = rfRise;
            CLK_SUB: next_st.tick = subTick;
            CLK_T0_UF: next_st.tick = timerZeroUnderflow;
            CLK_T1_UF: next_st.tick = timerOneUnderflow;
            default: next_st.tick = 1'b0;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            st <= '0;
        else
            st <= next_st;
    end

    assign tick = st.tick;
endmodule : rstmr_tick

// File: testbench/rstmr_timer_checker.sv
// rstmr_timer_checker: port-level assertions for the second timer, bound to rstmr_timer.
// assumes: one clock, async active-low reset, apb master keeps setup then access order.
`timescale 1ns/1ps
module rstmr_timer_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // apb
    input wire rstmr_pkg::rstmr_apb_req_t apbReq,
    input wire rstmr_pkg::rstmr_apb_rsp_t apbRsp,
    // pins and events
    input wire logic rfClkPin,
    input wire logic lfoPin,
    input wire logic txEnd,
    input wire logic rxFirstBits,
    input wire logic timerZeroUnderflow,
    input wire logic timerOneUnderflow,
    // results
    input wire logic irq,
    input wire logic underflowPulse
);
    import rstmr_pkg::*;
    logic setup;
    logic wrDone;
    logic rfLast;
    logic enSeen;
    logic [3:0] srcAge;

    // bus phases as seen on the wires
    assign setup = apbReq.psel && !apbReq.penable;
    assign wrDone = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready;

    // age of the last tick source, saturating; enable bit as last written
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rfLast <= 1'b0;
            srcAge <= 4'hf;
            enSeen <= 1'b0;
        end
        else
        begin
            rfLast <= rfClkPin;
            if (timerZeroUnderflow || timerOneUnderflow || rfClkPin != rfLast)
                srcAge <= 4'h0;
            else if (srcAge != 4'hf)
                srcAge <= srcAge + 4'h1;
            if (wrDone && apbReq.paddr == {IDX_IRQ_ENABLE, ALIGN_OK})
                enSeen <= apbReq.pwdata[0];
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    a_misalign_err: assert property (setup && apbReq.paddr[1:0] != ALIGN_OK
        |=> apbRsp.pslverr && apbRsp.prdata == '0) else $error("misaligned access not refused");
    a_unmapped_err: assert property (setup && apbReq.paddr == 10'h3fc |=> apbRsp.pslverr)
        else $error("unmapped access not refused");
    a_ctrl_reserved: assert property (
        setup && !apbReq.pwrite && apbReq.paddr == {IDX_CONTROL, ALIGN_OK}
        |=> apbRsp.prdata[31:8] == 24'h0 && !apbRsp.prdata[6] && !apbRsp.prdata[2] && !apbRsp.pslverr)
        else $error("control reserved bits not zero");
    a_count_bytes: assert property (
        setup && !apbReq.pwrite && (apbReq.paddr == {IDX_COUNT_HIGH, ALIGN_OK}
        || apbReq.paddr == {IDX_COUNT_LOW, ALIGN_OK}) |=> apbRsp.prdata[31:8] == 24'h0 && !apbRsp.pslverr)
        else $error("count byte read malformed");
    a_tick_cause: assert property (underflowPulse |-> srcAge <= 4'ha)
        else $error("underflow without a recent tick source");
    a_irq_on_uf: assert property (underflowPulse && enSeen |-> ##[0:1] irq)
        else $error("enabled underflow did not raise irq");
    a_clear_drops: assert property (
        (wrDone && apbReq.paddr == {IDX_IRQ_CLEAR, ALIGN_OK} && apbReq.pwdata[1:0] == 2'h3
        && !rxFirstBits && !$past(rxFirstBits) && !$past(rxFirstBits, 2))
        ##1 !underflowPulse && !rxFirstBits ##1 !underflowPulse |-> !irq) else $error("irq stays after clear");
    a_enable_off: assert property (
        wrDone && apbReq.paddr == {IDX_IRQ_ENABLE, ALIGN_OK} && apbReq.pwdata[1:0] == 2'h0
        |-> ##[1:2] !irq) else $error("irq stays with enables off");

    // main scenarios reached
    c_underflow: cover property (underflowPulse);
    c_irq: cover property ($rose(irq));
    c_refused: cover property (setup && apbReq.paddr[1:0] != ALIGN_OK);
endmodule : rstmr_timer_checker

bind rstmr_timer rstmr_timer_checker i_checker (.sys_clk(sys_clk), .nrst(nrst), .apbReq(apbReq),
    .apbRsp(apbRsp), .rfClkPin(rfClkPin), .lfoPin(lfoPin), .txEnd(txEnd), .rxFirstBits(rxFirstBits),
    .timerZeroUnderflow(timerZeroUnderflow), .timerOneUnderflow(timerOneUnderflow), .irq(irq),
    .underflowPulse(underflowPulse));

// File: testbench/rstmr_timer_tb.sv
// rstmr_timer_tb: self-checking bench for the second timer; reads are queued and checked by a monitor.
// assumes: rstmr_timer always ready on apb; neighbour underflows, events and pins are driven here.
`timescale 1ns/1ps
module rstmr_timer_tb;
    import rstmr_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    rstmr_apb_req_t apbReq = '0;
    rstmr_apb_rsp_t apbRsp;
    logic [3:0] ev = 4'h0;
    logic rfClkPin = 1'b0;
    logic lfoPin = 1'b0;
    logic rfRun = 1'b0;
    logic [2:0] rfDiv = 3'h0;
    logic irq;
    logic underflowPulse;
    logic [32:0] expQ[$];
    int failures = 0;
    int checksDone = 0;
    int ufSeen = 0;

    // 200 MHz system clock
    always #2.5 sys_clk = ~sys_clk;

    // carrier pin, 14 cycles a period, only while a carrier test runs
    always @(posedge sys_clk)
    begin
        if (rfRun)
        begin
            rfDiv <= (rfDiv == 3'h6) ? 3'h0 : rfDiv + 3'h1;
            if (rfDiv == 3'h6)
                rfClkPin <= ~rfClkPin;
        end
    end

    // ev: bit 0 timer zero, 1 timer one, 2 tx end, 3 first bits received
    rstmr_timer i_dut (.sys_clk(sys_clk), .nrst(nrst), .apbReq(apbReq), .apbRsp(apbRsp),
        .rfClkPin(rfClkPin), .lfoPin(lfoPin), .txEnd(ev[2]), .rxFirstBits(ev[3]),
        .timerZeroUnderflow(ev[0]), .timerOneUnderflow(ev[1]), .irq(irq), .underflowPulse(underflowPulse));

    task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] seen);
        checksDone++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // read answers taken in the access cycle, oldest note first
    always @(posedge sys_clk)
    begin
        if (apbReq.psel && apbReq.penable && !apbReq.pwrite && apbRsp.pready === 1'b1)
            chk("apb read", (expQ.size() > 0) ? expQ.pop_front() : 33'h1ffffffff, {apbRsp.pslverr, apbRsp.prdata});
        // cascade pulses counted for the underflow checks
        if (underflowPulse === 1'b1)
            ufSeen++;
    end

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge sys_clk);
        apbReq.penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (apbRsp.pready !== 1'b1);
        apbReq <= '0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, {idx, ALIGN_OK}, {24'h0, d});
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] v);
        expQ.push_back({1'b0, 24'h0, v});
        apb(1'b0, {idx, ALIGN_OK}, 32'h0);
    endtask : rd

    task automatic bad(input logic [9:0] a);
        expQ.push_back({1'b1, 32'h0});
        apb(1'b0, a, 32'h0);
    endtask : bad

    // count bytes read only between events, never inside a reception
    task automatic cnt(input logic [15:0] v);
        rd(IDX_COUNT_HIGH, v[15:8]);
        rd(IDX_COUNT_LOW, v[7:0]);
    endtask : cnt

    // n one-cycle pulses on the selected events, room for the tick path after each
    task automatic ping(input logic [3:0] m, input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            ev <= m;
            @(posedge sys_clk);
            ev <= 4'h0;
            repeat (3) @(posedge sys_clk);
        end
    endtask : ping

    // one trimming reference edge, long enough for the pin synchroniser
    task automatic low_freq_oscillator();
        @(posedge sys_clk);
        lfoPin <= 1'b1;
        repeat (8) @(posedge sys_clk);
        lfoPin <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask : low_freq_oscillator

    // stop, load reload and control, clear stale status
    task automatic run(input logic [7:0] ctrl, input logic [15:0] rl);
        wr(IDX_COMMAND, 8'h02);
        wr(IDX_RELOAD_HIGH, rl[15:8]);
        wr(IDX_RELOAD_LOW, rl[7:0]);
        wr(IDX_CONTROL, ctrl);
        wr(IDX_IRQ_CLEAR, 8'h03);
    endtask : run

    task automatic irqIs(input logic v);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("irq", {32'h0, v}, {32'h0, irq});
    endtask : irqIs

    task automatic final_report();
        if (failures == 0 && checksDone > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    // hang guard, well past the longest sequence
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        final_report();
    end

    initial
    begin
        logic [15:0] r;
        logic [7:0] d;
        void'($urandom(32'h45ad75e0));
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        // reset values, reserved bits, refused and ignored accesses
        rd(IDX_CONTROL, 8'h00);
        cnt(16'h0000);
        wr(IDX_CONTROL, 8'hff);
        rd(IDX_CONTROL, 8'hbb);
        d = 8'($urandom);
        wr(IDX_RELOAD_HIGH, d);
        rd(IDX_RELOAD_HIGH, d);
        bad(10'h065);
        bad(10'h3fc);
        wr(IDX_COUNT_LOW, 8'h55);
        cnt(16'h0000);
        wr(IDX_IRQ_ENABLE, 8'h03);
        // one-shot on timer zero underflows, reload rewritten mid-count
        r = 16'($urandom_range(9, 3));
        run(8'h02, r);
        wr(IDX_COMMAND, 8'h01);
        ping(4'h1, 1);
        cnt(r - 16'h1);
        wr(IDX_RELOAD_LOW, 8'h7f);
        ping(4'h1, 1);
        cnt(r - 16'h2);
        ping(4'h1, int'(r) - 2);
        irqIs(1'b1);
        chk("underflow pulses", 33'h1, 33'(ufSeen));
        rd(IDX_IRQ_STATUS, 8'h01);
        ping(4'h1, 1);
        cnt(16'h0000);
        // mask, unmask, clear
        wr(IDX_IRQ_ENABLE, 8'h00);
        irqIs(1'b0);
        wr(IDX_IRQ_ENABLE, 8'h03);
        irqIs(1'b1);
        wr(IDX_IRQ_CLEAR, 8'h03);
        irqIs(1'b0);
        wr(IDX_COMMAND, 8'h01);
        cnt(16'h007f);
        // auto restart
        run(8'h0a, 16'h0002);
        wr(IDX_COMMAND, 8'h01);
        ping(4'h1, 2);
        cnt(16'h0002);
        chk("underflow pulses", 33'h2, 33'(ufSeen));
        rd(IDX_IRQ_STATUS, 8'h01);
        // tx end ignored in mode 00, starts in mode 01
        run(8'h02, 16'h0005);
        ping(4'h4, 1);
        ping(4'h1, 1);
        cnt(16'h0002);
        wr(IDX_CONTROL, 8'h12);
        ping(4'h4, 1);
        ping(4'h1, 1);
        cnt(16'h0004);
        // stop on receive set, then clear
        run(8'h92, 16'h0006);
        ping(4'h4, 1);
        ping(4'h1, 1);
        ping(4'h8, 1);
        ping(4'h1, 1);
        cnt(16'h0005);
        rd(IDX_IRQ_STATUS, 8'h02);
        run(8'h12, 16'h0006);
        ping(4'h4, 1);
        ping(4'h8, 1);
        ping(4'h1, 1);
        cnt(16'h0005);
        // trimming: receive ignored, edge starts and stops, mode 10 silent at zero
        run(8'hb2, 16'h0006);
        low_freq_oscillator();
        ping(4'h8, 1);
        ping(4'h1, 1);
        cnt(16'h0005);
        low_freq_oscillator();
        ping(4'h1, 1);
        cnt(16'h0005);
        run(8'h22, 16'h0001);
        low_freq_oscillator();
        ping(4'h1, 1);
        cnt(16'h0000);
        rd(IDX_IRQ_STATUS, 8'h00);
        chk("underflow pulses", 33'h2, 33'(ufSeen));
        // clock sources: timer one, carrier, divided carrier
        run(8'h03, 16'h0004);
        wr(IDX_COMMAND, 8'h01);
        ping(4'h1, 1);
        ping(4'h2, 1);
        cnt(16'h0003);
        rfRun <= 1'b1;
        run(8'h00, 16'h0003);
        wr(IDX_COMMAND, 8'h01);
        repeat (200) @(posedge sys_clk);
        cnt(16'h0000);
        run(8'h01, 16'h0002);
        wr(IDX_COMMAND, 8'h01);
        repeat (300) @(posedge sys_clk);
        rd(IDX_IRQ_STATUS, 8'h00);
        repeat (2000) @(posedge sys_clk);
        rd(IDX_IRQ_STATUS, 8'h01);
        chk("underflow pulses", 33'h4, 33'(ufSeen));
        final_report();
    end
endmodule : rstmr_timer_tb
